/* logic/scq_chan.sv */
// One serial channel's operation-enable state and receive-enable settle timer.
`timescale 1ns/10ps
module scq_chan
  import scq_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  // Control
  scq_chan_if.chan  ch
);
  logic [2:0] settle_q;
  logic [2:0] settle_d;
  logic       en_q;
  logic       early_q;
  scq_mode_t  mode_w;

  assign mode_w   = scq_mode_t'({ch.txe, ch.rxe});
  assign settle_d = !ch.rxe ? 3'h0 : (settle_q == RX_SETUP_CNT ? settle_q : settle_q + 3'h1);
  assign ch.enabled = en_q;
  assign ch.early   = early_q;
  assign ch.mode    = mode_w;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_q <= 3'h0;
      en_q     <= 1'b0;
      early_q  <= 1'b0;
    end else begin
      settle_q <= settle_d;
      // Only a one starts the channel; a zero leaves it as it is.
      if (ch.start) begin
        en_q <= 1'b1;
      end
      // Flags a start issued before the receiver had settled.
      if (ch.start && ch.rxe && settle_q < RX_SETUP_CNT) begin
        early_q <= 1'b1;
      end
    end
  end
endmodule // scq_chan

/* logic/scq_chan_if.sv */
// Interface carrying one channel's control and state between the top and a channel module.
`timescale 1ns/10ps
interface scq_chan_if;
  logic            start;
  logic            txe;
  logic            rxe;
  logic            enabled;
  logic            early;
  logic [1:0]      mode;
  modport ctrl (output start, output txe, output rxe, input enabled, input early, input mode);
  modport chan (input start, input txe, input rxe, output enabled, output early, output mode);
endinterface

/* logic/scq_pkg.sv */
// Package with register map, field positions and timing constants for the serial interrupt block.
package scq_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] OFS_REQ_FLAGS  = 4'h0;
  localparam logic [3:0] OFS_MASK_FLAGS = 4'h1;
  localparam logic [3:0] OFS_START_TRIG = 4'h2;
  localparam logic [3:0] OFS_CHAN_STAT  = 4'h3;
  localparam logic [3:0] OFS_CHAN_CFG0  = 4'h4;
  localparam logic [3:0] OFS_CHAN_CFG1  = 4'h5;
  localparam logic [3:0] OFS_RX_EARLY   = 4'h6;
  localparam int unsigned BIT_RX_ERR = 5;
  localparam int unsigned BIT_RX_END = 2;
  localparam int unsigned BIT_TX_END = 1;
  localparam logic [7:0] IRQ_FIELDS  = 8'h26;
  localparam logic [7:0] FLAG_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'hFF;
  localparam int unsigned BIT_TXE = 15;
  localparam int unsigned BIT_RXE = 14;
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned RX_SETUP_CLKS = 4;
  localparam logic [2:0]  RX_SETUP_CNT  = 3'(RX_SETUP_CLKS);
  typedef enum logic [1:0] {SCQ_PROHIBIT, SCQ_RX_ONLY, SCQ_TX_ONLY, SCQ_FULL} scq_mode_t;
endpackage

/* logic/scq_top.sv */
// Top of the serial channel interrupt flag, mask and start trigger block.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module scq_top
  import scq_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  rst_b_in,
  // Register port
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [DATA_W-1:0]     rdata_out,
  // Events from the serial engine
  input  wire logic                  rx_end_evt_in,
  input  wire logic                  rx_err_evt_in,
  input  wire logic                  tx_end_evt_in,
  // Channel state
  output logic      [NUM_CHAN-1:0]   chan_enabled_out,
  output logic      [2*NUM_CHAN-1:0] chan_mode_out,
  // Interrupts
  output logic                       rx_end_interrupt_out,
  output logic                       rx_err_interrupt_out,
  output logic                       tx_end_interrupt_out,
  output logic                       irq_out
);
  // Interrupt sources in output order: transmit end, receive end, receive error.
  localparam int unsigned NUM_LINES = 3;
  localparam int unsigned LINE_BIT [NUM_LINES] = '{BIT_TX_END, BIT_RX_END, BIT_RX_ERR};

  logic                  rst_s1_q;
  logic                  rst_s2_q;
  logic [7:0]            flags_q;
  logic [7:0]            flags_d;
  logic [7:0]            mask_q;
  logic [7:0]            mask_d;
  logic [DATA_W-1:0]     cfg_q [NUM_CHAN];
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic [7:0]            evt_w;
  logic [7:0]            pend_w;
  logic [NUM_CHAN-1:0]   en_w;
  logic [NUM_CHAN-1:0]   early_w;
  logic [2*NUM_CHAN-1:0] mode_w;
  logic                  wr_flags_w;
  logic                  wr_mask_w;
  logic                  wr_start_w;
  logic                  irq_q;
  logic [2:0]            irqs_q;
  logic [NUM_CHAN-1:0]   en_q;
  logic [2*NUM_CHAN-1:0] mode_q;
  logic [NUM_CHAN-1:0]   cfg_wr_w;
  logic [NUM_LINES-1:0]  src_evt_w;
  logic [NUM_LINES-1:0]  irqs_d;
  logic                  irq_d;
  // Read decode and the words each readable register presents.
  logic                  rd_flags_w;
  logic                  rd_mask_w;
  logic                  rd_stat_w;
  logic                  rd_cfg0_w;
  logic                  rd_cfg1_w;
  logic                  rd_early_w;
  logic [DATA_W-1:0]     flags_word_w;
  logic [DATA_W-1:0]     mask_word_w;
  logic [DATA_W-1:0]     stat_word_w;
  logic [DATA_W-1:0]     early_word_w;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // Reset is released through two flops so release is clean against the clock.
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Write decode; each register sees its own strobe.
  assign wr_flags_w = wr_in && hit(addr_in, OFS_REQ_FLAGS);
  assign wr_mask_w  = wr_in && hit(addr_in, OFS_MASK_FLAGS);
  assign wr_start_w = wr_in && hit(addr_in, OFS_START_TRIG);

  assign src_evt_w = {rx_err_evt_in, rx_end_evt_in, tx_end_evt_in};

  // Each source lands at its own flag position; the other bits never see an event.
  always_comb begin
    evt_w = 8'h00;
    for (int l = 0; l < NUM_LINES; l++) begin
      evt_w[LINE_BIT[l]] = src_evt_w[l];
    end
  end

  // Write one clears; a new event in the same cycle wins over the clear.
  assign flags_d = ((flags_q & ~(wr_flags_w ? wdata_in[7:0] : 8'h00)) | evt_w)
                 & IRQ_FIELDS;
  assign mask_d  = wr_mask_w ? ((wdata_in[7:0] & IRQ_FIELDS) | ~IRQ_FIELDS) : mask_q;
  assign pend_w  = flags_q & ~mask_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      scq_chan_if cif ();
      assign cfg_wr_w[gi] = wr_in && hit(addr_in, (gi == 0) ? OFS_CHAN_CFG0 : OFS_CHAN_CFG1);
      assign cif.start = wr_start_w && wdata_in[gi];
      assign cif.txe   = cfg_q[gi][BIT_TXE];
      assign cif.rxe   = cfg_q[gi][BIT_RXE];
      assign en_w[gi]      = cif.enabled;
      assign early_w[gi]   = cif.early;
      assign mode_w[2*gi +: 2] = cif.mode;
      scq_chan scq_chan_i (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_s2_q),
        .ch       (cif.chan)
      );
    end
  endgenerate

  // Channel configuration words; only the two enable bits act here, the rest is kept for software.
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        cfg_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (cfg_wr_w[c]) begin
          cfg_q[c] <= wdata_in;
        end
      end
    end
  end

  // One select per readable register, so an unmapped index reads as zero.
  assign rd_flags_w   = rd_in && hit(addr_in, OFS_REQ_FLAGS);
  assign rd_mask_w    = rd_in && hit(addr_in, OFS_MASK_FLAGS);
  assign rd_stat_w    = rd_in && hit(addr_in, OFS_CHAN_STAT);
  assign rd_cfg0_w    = rd_in && hit(addr_in, OFS_CHAN_CFG0);
  assign rd_cfg1_w    = rd_in && hit(addr_in, OFS_CHAN_CFG1);
  assign rd_early_w   = rd_in && hit(addr_in, OFS_RX_EARLY);
  assign flags_word_w = DATA_W'(flags_q);
  assign mask_word_w  = DATA_W'(mask_q);
  assign stat_word_w  = DATA_W'(en_w);
  assign early_word_w = DATA_W'(early_w);
  // The start trigger is write only and falls through to zero like any unmapped index.
  assign rdata_d = ({DATA_W{rd_flags_w}} & flags_word_w)
                 | ({DATA_W{rd_mask_w}}  & mask_word_w)
                 | ({DATA_W{rd_stat_w}}  & stat_word_w)
                 | ({DATA_W{rd_cfg0_w}}  & cfg_q[0])
                 | ({DATA_W{rd_cfg1_w}}  & cfg_q[1])
                 | ({DATA_W{rd_early_w}} & early_word_w);

  // The summary line is taken from next values so that it rises with the flag; the
  // per-source lines follow one edge later from the settled flag and mask.
  assign irq_d = |(flags_d & ~mask_d);
  genvar li;
  generate
    for (li = 0; li < NUM_LINES; li++) begin : g_line
      assign irqs_d[li] = pend_w[LINE_BIT[li]];
    end
  endgenerate

  // Reset leaves every interrupt masked until software opens it.
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      flags_q <= FLAG_RESET;
      mask_q  <= MASK_RESET;
    end else begin
      flags_q <= flags_d;
      mask_q  <= mask_d;
    end
  end

  // Read data stand for exactly one cycle; a cycle without a read returns zero.
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      irq_q  <= 1'b0;
      irqs_q <= '0;
    end else begin
      irq_q  <= irq_d;
      irqs_q <= irqs_d;
    end
  end

  // Channel state leaves through flops so that every top output is registered.
  always_ff @(posedge mclk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      en_q   <= '0;
      mode_q <= '0;
    end else begin
      en_q   <= en_w;
      mode_q <= mode_w;
    end
  end

  assign rdata_out            = rdata_q;
  assign irq_out              = irq_q;
  assign rx_err_interrupt_out = irqs_q[2];
  assign rx_end_interrupt_out = irqs_q[1];
  assign tx_end_interrupt_out = irqs_q[0];
  assign chan_enabled_out     = en_q;
  assign chan_mode_out        = mode_q;
endmodule // scq_top

/* testbench/scq_checker.sv */
// Concurrent checks on the ports of the serial interrupt block.
`timescale 1ns/10ps
module scq_checker
  import scq_pkg::*;
(
  // Clock and reset
  input wire logic                mclk_in,
  input wire logic                rst_b_in,
  // Register port
  input wire logic [ADDR_W-1:0]   addr_in,
  input wire logic [DATA_W-1:0]   wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [DATA_W-1:0]   rdata_out,
  // Events
  input wire logic                rx_end_evt_in,
  input wire logic                rx_err_evt_in,
  input wire logic                tx_end_evt_in,
  // Channel state and interrupts
  input wire logic [NUM_CHAN-1:0] chan_enabled_out,
  input wire logic                rx_end_interrupt_out,
  input wire logic                rx_err_interrupt_out,
  input wire logic                tx_end_interrupt_out,
  input wire logic                irq_out
);
  logic [7:0] mask_m;
  logic [7:0] mask_nx;
  wire start_w = wr_in && addr_in == OFS_START_TRIG;
  wire any_w = rx_end_interrupt_out | rx_err_interrupt_out | tx_end_interrupt_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // Mask mirror; bits without an interrupt always read as set.
  // The mask taking effect at this edge, so a mask write beside an event is judged right.
  assign mask_nx = (wr_in && addr_in == OFS_MASK_FLAGS) ?
                   (wdata_in[7:0] | ~IRQ_FIELDS) : mask_m;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_m <= MASK_RESET;
    end else begin
      mask_m <= mask_nx;
    end
  end
  sequence s_raise(logic line); irq_out ##1 line; endsequence
  sequence s_quiet(logic line); !wr_in ##1 line; endsequence
  AST_RX_END: assert property (
    rx_end_evt_in && !mask_nx[BIT_RX_END] |=> s_raise(rx_end_interrupt_out))
    else $error("rx end not raised");
  AST_RX_ERR: assert property (
    rx_err_evt_in && !mask_nx[BIT_RX_ERR] |=> s_raise(rx_err_interrupt_out))
    else $error("rx error not raised");
  AST_TX_END: assert property (
    tx_end_evt_in && !mask_nx[BIT_TX_END] |=> s_raise(tx_end_interrupt_out))
    else $error("tx end not raised");
  AST_STICKY: assert property (s_quiet(rx_end_interrupt_out) |=> rx_end_interrupt_out)
    else $error("request dropped without a clear");
  AST_IRQ_AGREE: assert property (any_w == $past(irq_out))
    else $error("irq and lines disagree");
  AST_MASK_READ: assert property (rd_in && addr_in == OFS_MASK_FLAGS |=> rdata_out[7:0] == mask_m)
    else $error("mask read wrong");
  AST_START: assert property (start_w |=> ##1 &(chan_enabled_out | ~$past(wdata_in[1:0], 2)))
    else $error("start did not enable");
  AST_NO_STOP: assert property (&(chan_enabled_out | ~$past(chan_enabled_out)))
    else $error("channel stopped");
endmodule // scq_checker
bind scq_top scq_checker scq_checker_i (
  .mclk_in              (mclk_in),
  .rst_b_in             (rst_b_in),
  .addr_in              (addr_in),
  .wdata_in             (wdata_in),
  .wr_in                (wr_in),
  .rd_in                (rd_in),
  .rdata_out            (rdata_out),
  .rx_end_evt_in        (rx_end_evt_in),
  .rx_err_evt_in        (rx_err_evt_in),
  .tx_end_evt_in        (tx_end_evt_in),
  .chan_enabled_out     (chan_enabled_out),
  .rx_end_interrupt_out (rx_end_interrupt_out),
  .rx_err_interrupt_out (rx_err_interrupt_out),
  .tx_end_interrupt_out (tx_end_interrupt_out),
  .irq_out              (irq_out)
);

/* testbench/scq_remote.sv */
// Far station model, reduced to the one-cycle events its frames cause.
`timescale 1ns/10ps
module scq_remote (
  input  wire logic       mclk_in,
  input  wire logic [2:0] send_in,
  output logic            rx_err_evt_out = 1'b0,
  output logic            rx_end_evt_out = 1'b0,
  output logic            tx_end_evt_out = 1'b0
);
  // Each event repeats its send_in bit one clock later, so a one-cycle send yields exactly one pulse.
  always @(posedge mclk_in) begin
    rx_err_evt_out <= send_in[2];
    rx_end_evt_out <= send_in[1];
    tx_end_evt_out <= send_in[0];
  end
endmodule // scq_remote

/* testbench/test_serial_channel_irq_and_start.sv */
// Self-checking bench for the serial interrupt flag, mask and start block.
`timescale 1ns/10ps
module test_serial_channel_irq_and_start;
  import scq_pkg::*;
  logic mclk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_out;
  logic [3:0] addr_in = 4'h0, chan_mode_out;
  logic [15:0] wdata_in = 16'h0000, rdata_out, v;
  logic [2:0] send = 3'h0;
  logic [1:0] chan_enabled_out;
  wire [2:0] ev, line;
  int bad_count = 0, checks_done = 0;
  always #20 mclk_in = ~mclk_in;
  scq_remote scq_remote_i (.mclk_in, .send_in(send), .rx_err_evt_out(ev[2]),
    .rx_end_evt_out(ev[1]), .tx_end_evt_out(ev[0]));
  scq_top scq_top_i (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_end_evt_in(ev[1]), .rx_err_evt_in(ev[2]), .tx_end_evt_in(ev[0]), .chan_enabled_out,
    .chan_mode_out, .rx_end_interrupt_out(line[1]), .rx_err_interrupt_out(line[2]),
    .tx_end_interrupt_out(line[0]), .irq_out);
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic fire(input int k);
    @(posedge mclk_in);
    send <= 3'(1 << k);
    @(posedge mclk_in);
    send <= 3'h0;
    idle(3);
  endtask
  task automatic t_events;
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 8'h02 : (k == 1) ? 8'h04 : 8'h20;
      fire(k);
      chk({12'h000, line, irq_out}, 16'h0000);
      rd(OFS_REQ_FLAGS);
      chk(v & 16'h00FF, {8'h00, b});
      wr(OFS_MASK_FLAGS, {8'hFF, ~b});
      idle(6);
      chk({12'h000, line, irq_out}, {12'h000, 3'(1 << k), 1'b1});
      wr(OFS_REQ_FLAGS, {8'h00, b});
      idle(2);
      chk({12'h000, line, irq_out}, 16'h0000);
      fire(k);
      chk({12'h000, line, irq_out}, {12'h000, 3'(1 << k), 1'b1});
      wr(OFS_REQ_FLAGS, {8'h00, b});
      wr(OFS_MASK_FLAGS, 16'h00FF);
    end
  endtask
  task automatic t_start;
    wr(OFS_CHAN_CFG0, 16'h4000);
    idle(4);
    wr(OFS_START_TRIG, 16'h0000);
    idle(2);
    chk(16'(chan_enabled_out), 16'h0000);
    wr(OFS_START_TRIG, 16'h0001);
    idle(2);
    chk({chan_mode_out, 10'h000, chan_enabled_out}, 16'h1001);
    wr(OFS_CHAN_CFG1, 16'hC000);
    wr(OFS_CHAN_CFG0, 16'h8000);
    idle(4);
    wr(OFS_START_TRIG, 16'h0002);
    idle(2);
    chk({chan_mode_out, 10'h000, chan_enabled_out}, 16'hE003);
    wr(OFS_CHAN_CFG0, 16'h0000);
    wr(OFS_START_TRIG, 16'h0000);
    idle(3);
    chk({chan_mode_out, 10'h000, chan_enabled_out}, 16'hC003);
    rd(OFS_CHAN_STAT);
    chk(v, 16'h0003);
    rd(OFS_CHAN_CFG1);
    chk(v, 16'hC000);
    rd(OFS_RX_EARLY);
    chk(v, 16'h0000);
    wr(OFS_CHAN_CFG0, 16'h4000);
    wr(OFS_START_TRIG, 16'h0001);
    rd(OFS_RX_EARLY);
    chk(v, 16'h0001);
    rd(OFS_START_TRIG);
    chk(v, 16'h0000);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    idle(3);
    rd(OFS_MASK_FLAGS);
    chk(v & 16'h00FF, 16'(MASK_RESET));
    rd(4'hF);
    chk(v, 16'h0000);
    t_events;
    t_start;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge mclk_in);
    bad_count++;
    give_verdict;
  end
endmodule // test_serial_channel_irq_and_start
